/* File: chan_store.sv */
`timescale 1ns/1ps
module chan_store #(
    parameter int DEPTH = 8,
    parameter int IDXW = 3
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic clr,
    input wire logic we,
    input wire logic [IDXW-1:0] waddr,
    input wire eq_cfg_pkg::ch_cfg_s wdata,
    input wire logic [IDXW-1:0] raddr,
    output eq_cfg_pkg::ch_cfg_s rdata,
    output eq_cfg_pkg::ch_cfg_s [DEPTH-1:0] all
);
    if (DEPTH < 1 || DEPTH > (1 << IDXW)) begin : g_check
        $error("DEPTH does not fit the index width");
    end

    // ==========================================================
    // One independent word per channel
    // ==========================================================
    for (genvar i = 0; i < DEPTH; i++) begin : g_entry
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                all[i] <= eq_cfg_pkg::CH_CFG_RESET;
            end else if (ce) begin
                if (clr) begin
                    all[i] <= eq_cfg_pkg::CH_CFG_RESET;
                end else if (we && waddr == IDXW'(i)) begin
                    all[i] <= wdata;
                end
            end
        end
    end

    // ==========================================================
    // Registered read port
    // ==========================================================
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= eq_cfg_pkg::CH_CFG_RESET;
        end else if (ce) begin
            rdata <= (int'(raddr) < DEPTH) ? all[raddr] : eq_cfg_pkg::CH_CFG_RESET;
        end
    end

endmodule // chan_store

/* File: eq_cfg_pkg.sv */
package eq_cfg_pkg;

    // ==========================================================
    // Strap levels and carriers
    // ==========================================================
    typedef enum logic [1:0] {LVL_LOW, LVL_OPEN, LVL_HIGH} lvl_e;

    // One bit per three-state strap, sampled with a weak pull applied
    typedef struct packed {
        logic enable;
        logic profile;
        logic swing;
        logic gain;
        logic peak;
    } strap_s;

    // Per-channel setting word, also the low byte of a channel register
    typedef struct packed {
        logic [3:0] peaking_code;
        logic [1:0] gain_code;
        logic [1:0] swing_code;
    } ch_cfg_s;

    // Classic Wishbone request from the master
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wb_req_s;

    // ==========================================================
    // Strap to code tables
    // ==========================================================
    localparam logic [3:0] PEAK_LONG_HI = 4'he;
    localparam logic [3:0] PEAK_LONG_OPEN = 4'h9;
    localparam logic [3:0] PEAK_LONG_LO = 4'h5;
    localparam logic [3:0] PEAK_SHORT_HI = 4'h9;
    localparam logic [3:0] PEAK_SHORT_OPEN = 4'h5;
    localparam logic [3:0] PEAK_SHORT_LO = 4'h3;
    localparam logic [1:0] GAIN_LONG_HI = 2'h3;
    localparam logic [1:0] GAIN_LONG_OPEN = 2'h2;
    localparam logic [1:0] GAIN_LONG_LO = 2'h1;
    localparam logic [1:0] GAIN_SHORT_HI = 2'h2;
    localparam logic [1:0] GAIN_SHORT_OPEN = 2'h1;
    localparam logic [1:0] GAIN_SHORT_LO = 2'h0;
    localparam logic [1:0] SWING_HI = 2'h3;
    localparam logic [1:0] SWING_OPEN = 2'h2;
    localparam logic [1:0] SWING_LO = 2'h1;

    // ==========================================================
    // Register map and fields
    // ==========================================================
    localparam logic [7:0] STATUS_OFF = 8'h00;
    localparam logic [7:0] POWER_OFF = 8'h04;
    localparam logic [7:0] CHAN_OFF = 8'h20;
    localparam int ST_SERIAL = 0;
    localparam int ST_SHORT = 1;
    localparam int ST_RUN = 2;
    localparam int ST_PEAK = 3;
    localparam int ST_GAIN = 5;
    localparam int ST_SWING = 7;
    localparam int ST_ENABLE = 9;
    localparam ch_cfg_s CH_CFG_RESET = '{peaking_code: 4'h9, gain_code: 2'h2, swing_code: 2'h2};

endpackage

/* File: eq_setting_pin_decoder.sv */
`timescale 1ns/1ps
// Behaviour
// - Straps or serial bus supply all settings
// - Profile strap high selects short, else long
// - Pin mode: one peaking code for all
// - Long profile peaking: 1110, 1001, 0101
// - Short profile peaking: 1001, 0101, 0011
// - Long profile gain: 11, 10, 01
// - Short profile gain: 10, 01, 00
// - Swing code: 11, 10, 01 always
// - Serial mode: sixteen peaking codes per channel
// - Serial mode: channel writes stay independent
// - Enable strap high powers channels down
// - Enable strap open powers channels up
// - Enable strap low: reset, bus blocked
module eq_setting_pin_decoder #(
    parameter int NUM_CH = 8
) (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic CE,
    input wire logic MODE_SEL,
    input wire eq_cfg_pkg::strap_s STRAP_PU,
    input wire eq_cfg_pkg::strap_s STRAP_PD,
    input wire eq_cfg_pkg::wb_req_s WB_REQ,
    output logic WB_ACK,
    output logic WB_ERR,
    output logic [31:0] WB_DAT,
    output eq_cfg_pkg::ch_cfg_s [NUM_CH-1:0] CH_CFG,
    output logic [NUM_CH-1:0] CH_PWRDN,
    output logic SERIAL_MODE,
    output logic CFG_VALID
);
    localparam int IDXW = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;

    if (NUM_CH < 1 || NUM_CH > 8) begin : g_check
        $error("NUM_CH must lie between 1 and 8");
    end

    typedef enum logic [1:0] {CORE_HOLD, CORE_LOAD, CORE_RUN} core_e;
    typedef enum logic [1:0] {BUS_IDLE, BUS_WAIT, BUS_ANSWER} bus_e;

    typedef struct packed {
        core_e core;
        bus_e bus;
        logic serial;
        logic short_prof;
        eq_cfg_pkg::lvl_e peak_l;
        eq_cfg_pkg::lvl_e gain_l;
        eq_cfg_pkg::lvl_e swing_l;
        logic [NUM_CH-1:0] pwrdn;
        logic ack;
        logic err;
        logic [31:0] dat;
        eq_cfg_pkg::ch_cfg_s [NUM_CH-1:0] cfg;
        logic [NUM_CH-1:0] out_pwrdn;
        logic valid;
    } state_s;

    localparam state_s STATE_RESET = '{
        core: CORE_HOLD, bus: BUS_IDLE, serial: 1'b0, short_prof: 1'b0,
        peak_l: eq_cfg_pkg::LVL_OPEN, gain_l: eq_cfg_pkg::LVL_OPEN,
        swing_l: eq_cfg_pkg::LVL_OPEN, pwrdn: '1, ack: 1'b0, err: 1'b0,
        dat: 32'h0, cfg: {NUM_CH{eq_cfg_pkg::CH_CFG_RESET}},
        out_pwrdn: '1, valid: 1'b0};

    // ==========================================================
    // Reset release
    // ==========================================================
    logic [1:0] rst_sync;
    logic rst_n;

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            rst_sync <= 2'h0;
        end else if (CE) begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // ==========================================================
    // Strap resolution
    // ==========================================================
    // Pull-up sample high and pull-down sample low means nobody drives
    // the pin; a contradictory pair is also read as open.
    function automatic eq_cfg_pkg::lvl_e resolve(input logic pu, input logic pd);
        if (pu && pd) begin
            return eq_cfg_pkg::LVL_HIGH;
        end else if (!pu && !pd) begin
            return eq_cfg_pkg::LVL_LOW;
        end else begin
            return eq_cfg_pkg::LVL_OPEN;
        end
    endfunction

    function automatic eq_cfg_pkg::ch_cfg_s pin_cfg(input logic shrt,
        input eq_cfg_pkg::lvl_e p, input eq_cfg_pkg::lvl_e g, input eq_cfg_pkg::lvl_e w);
        eq_cfg_pkg::ch_cfg_s c;
        c = eq_cfg_pkg::CH_CFG_RESET;
        case (p)
            eq_cfg_pkg::LVL_HIGH: begin
                c.peaking_code = shrt ? eq_cfg_pkg::PEAK_SHORT_HI : eq_cfg_pkg::PEAK_LONG_HI;
            end
            eq_cfg_pkg::LVL_LOW: begin
                c.peaking_code = shrt ? eq_cfg_pkg::PEAK_SHORT_LO : eq_cfg_pkg::PEAK_LONG_LO;
            end
            default: begin
                c.peaking_code = shrt ? eq_cfg_pkg::PEAK_SHORT_OPEN : eq_cfg_pkg::PEAK_LONG_OPEN;
            end
        endcase
        case (g)
            eq_cfg_pkg::LVL_HIGH: begin
                c.gain_code = shrt ? eq_cfg_pkg::GAIN_SHORT_HI : eq_cfg_pkg::GAIN_LONG_HI;
            end
            eq_cfg_pkg::LVL_LOW: begin
                c.gain_code = shrt ? eq_cfg_pkg::GAIN_SHORT_LO : eq_cfg_pkg::GAIN_LONG_LO;
            end
            default: begin
                c.gain_code = shrt ? eq_cfg_pkg::GAIN_SHORT_OPEN : eq_cfg_pkg::GAIN_LONG_OPEN;
            end
        endcase
        case (w)
            eq_cfg_pkg::LVL_HIGH: c.swing_code = eq_cfg_pkg::SWING_HI;
            eq_cfg_pkg::LVL_LOW: c.swing_code = eq_cfg_pkg::SWING_LO;
            default: c.swing_code = eq_cfg_pkg::SWING_OPEN;
        endcase
        return c;
    endfunction

    eq_cfg_pkg::lvl_e en_l;
    logic hold;
    assign en_l = resolve(STRAP_PU.enable, STRAP_PD.enable);
    assign hold = (en_l == eq_cfg_pkg::LVL_LOW);

    // ==========================================================
    // Address decode
    // ==========================================================
    logic [7:0] chan_off;
    logic chan_hit;
    logic [IDXW-1:0] chan_idx;
    // Low two address bits are ignored, so unaligned offsets alias
    assign chan_off = WB_REQ.adr - eq_cfg_pkg::CHAN_OFF;
    assign chan_hit = (WB_REQ.adr >= eq_cfg_pkg::CHAN_OFF) && (chan_off[7:2] < 6'(NUM_CH));
    assign chan_idx = chan_off[2 +: IDXW];

    // ==========================================================
    // Per-channel store
    // ==========================================================
    state_s s;
    state_s next_s;
    logic store_we;
    eq_cfg_pkg::ch_cfg_s store_rdata;
    eq_cfg_pkg::ch_cfg_s [NUM_CH-1:0] store_all;

    chan_store #(
        .DEPTH(NUM_CH),
        .IDXW(IDXW)
    ) u_store (
        .clk(CLK),
        .rst_n(rst_n),
        .ce(CE),
        .clr(hold),
        .we(store_we),
        .waddr(chan_idx),
        .wdata(WB_REQ.dat[7:0]),
        .raddr(chan_idx),
        .rdata(store_rdata),
        .all(store_all)
    );

    // ==========================================================
    // Next state
    // ==========================================================
    logic [31:0] status;
    logic is_write;

    always_comb begin
        next_s = s;
        next_s.ack = 1'b0;
        next_s.err = 1'b0;
        store_we = 1'b0;
        is_write = WB_REQ.we && WB_REQ.sel[0] && s.core == CORE_RUN && s.serial;
        status = 32'h0;
        status[eq_cfg_pkg::ST_SERIAL] = s.serial;
        status[eq_cfg_pkg::ST_SHORT] = s.short_prof;
        status[eq_cfg_pkg::ST_RUN] = s.valid;
        status[eq_cfg_pkg::ST_PEAK +: 2] = s.peak_l;
        status[eq_cfg_pkg::ST_GAIN +: 2] = s.gain_l;
        status[eq_cfg_pkg::ST_SWING +: 2] = s.swing_l;
        status[eq_cfg_pkg::ST_ENABLE +: 2] = en_l;

        case (s.core)
            CORE_HOLD: begin
                next_s.core = CORE_LOAD;
            end
            CORE_LOAD: begin
                // Source select and straps are taken once, right after release
                next_s.serial = MODE_SEL;
                next_s.short_prof = resolve(STRAP_PU.profile, STRAP_PD.profile)
                    == eq_cfg_pkg::LVL_HIGH;
                next_s.peak_l = resolve(STRAP_PU.peak, STRAP_PD.peak);
                next_s.gain_l = resolve(STRAP_PU.gain, STRAP_PD.gain);
                next_s.swing_l = resolve(STRAP_PU.swing, STRAP_PD.swing);
                next_s.pwrdn = {NUM_CH{en_l == eq_cfg_pkg::LVL_HIGH}};
                next_s.core = CORE_RUN;
            end
            default: begin
                if (!s.serial) begin
                    // Pin mode follows the enable strap for as long as it runs
                    next_s.pwrdn = {NUM_CH{en_l == eq_cfg_pkg::LVL_HIGH}};
                end
            end
        endcase

        case (s.bus)
            BUS_IDLE: begin
                if (WB_REQ.cyc && WB_REQ.stb) begin
                    next_s.bus = BUS_WAIT;
                end
            end
            BUS_WAIT: begin
                next_s.bus = BUS_ANSWER;
                next_s.dat = 32'h0;
                if (s.core != CORE_RUN || hold) begin
                    next_s.err = 1'b1;
                end else begin
                    next_s.ack = 1'b1;
                    if (WB_REQ.adr == eq_cfg_pkg::STATUS_OFF) begin
                        next_s.dat = status;
                    end else if (WB_REQ.adr == eq_cfg_pkg::POWER_OFF) begin
                        next_s.dat[NUM_CH-1:0] = s.pwrdn;
                        if (is_write) begin
                            next_s.pwrdn = WB_REQ.dat[NUM_CH-1:0];
                        end
                    end else if (chan_hit) begin
                        next_s.dat[7:0] = store_rdata;
                        store_we = is_write;
                    end
                end
            end
            default: begin
                next_s.bus = BUS_IDLE;
            end
        endcase

        // Outputs are re-registered so every pin comes from a flop
        next_s.valid = (s.core == CORE_RUN);
        if (s.core != CORE_RUN) begin
            next_s.cfg = {NUM_CH{eq_cfg_pkg::CH_CFG_RESET}};
            next_s.out_pwrdn = '1;
        end else if (s.serial) begin
            next_s.cfg = store_all;
            next_s.out_pwrdn = s.pwrdn;
        end else begin
            next_s.cfg = {NUM_CH{pin_cfg(s.short_prof, s.peak_l, s.gain_l, s.swing_l)}};
            next_s.out_pwrdn = s.pwrdn;
        end

        if (hold) begin
            // Everything but the bus handshake returns to defaults
            next_s.core = CORE_HOLD;
            next_s.serial = STATE_RESET.serial;
            next_s.short_prof = STATE_RESET.short_prof;
            next_s.peak_l = STATE_RESET.peak_l;
            next_s.gain_l = STATE_RESET.gain_l;
            next_s.swing_l = STATE_RESET.swing_l;
            next_s.pwrdn = STATE_RESET.pwrdn;
            // Outputs drop at once so no stale setting outlives the reset
            next_s.valid = STATE_RESET.valid;
            next_s.cfg = STATE_RESET.cfg;
            next_s.out_pwrdn = STATE_RESET.out_pwrdn;
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            s <= STATE_RESET;
        end else if (CE) begin
            s <= next_s;
        end
    end

    assign WB_ACK = s.ack;
    assign WB_ERR = s.err;
    assign WB_DAT = s.dat;
    assign CH_CFG = s.cfg;
    assign CH_PWRDN = s.out_pwrdn;
    assign SERIAL_MODE = s.serial;
    assign CFG_VALID = s.valid;

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!rst_n);

    sequence bus_request;
        CE && s.bus == BUS_IDLE && WB_REQ.cyc && WB_REQ.stb;
    endsequence
    sequence bus_reply;
        CE [*2] ##1 (WB_ACK || WB_ERR) ##1 !(WB_ACK || WB_ERR);
    endsequence

    logic run_pin;
    assign run_pin = CE && s.core == CORE_RUN && !s.serial && !hold;

    serial_source_a: assert property (CE && s.core == CORE_RUN && s.serial && !hold |=>
        CH_CFG == $past(store_all)) else $error("serial settings not applied");
    profile_pick_a: assert property (CE && s.core == CORE_LOAD && !hold |=>
        s.short_prof == (resolve($past(STRAP_PU.profile), $past(STRAP_PD.profile))
        == eq_cfg_pkg::LVL_HIGH)) else $error("wrong channel profile");
    pin_global_a: assert property (run_pin |=> CH_CFG == {NUM_CH{CH_CFG[0]}})
        else $error("channels differ in pin mode");
    long_peak_a: assert property (run_pin && !s.short_prof && s.peak_l == eq_cfg_pkg::LVL_HIGH
        |=> CH_CFG[0].peaking_code == 4'he) else $error("long peaking code wrong");
    short_peak_a: assert property (run_pin && s.short_prof && s.peak_l == eq_cfg_pkg::LVL_LOW
        |=> CH_CFG[0].peaking_code == 4'h3) else $error("short peaking code wrong");
    long_gain_a: assert property (run_pin && !s.short_prof && s.gain_l == eq_cfg_pkg::LVL_OPEN
        |=> CH_CFG[0].gain_code == 2'h2) else $error("long gain code wrong");
    short_gain_a: assert property (run_pin && s.short_prof && s.gain_l == eq_cfg_pkg::LVL_LOW
        |=> CH_CFG[0].gain_code == 2'h0) else $error("short gain code wrong");
    swing_code_a: assert property (run_pin && s.swing_l == eq_cfg_pkg::LVL_LOW
        |=> CH_CFG[0].swing_code == 2'h1) else $error("swing code wrong");
    chan_write_a: assert property (CE && store_we && chan_idx == '0 |=>
        store_all[0] == $past(WB_REQ.dat[7:0])) else $error("channel write lost");
    chan_keep_a: assert property (CE && store_we && chan_idx != '0 && !hold |=>
        $stable(store_all[0])) else $error("other channel disturbed");
    power_down_a: assert property (run_pin && en_l == eq_cfg_pkg::LVL_HIGH |=> ##1
        CH_PWRDN == '1) else $error("channels not powered down");
    power_up_a: assert property (run_pin && en_l == eq_cfg_pkg::LVL_OPEN ##1
        run_pin |=> CH_PWRDN == '0) else $error("channels not powered up");
    hold_reset_a: assert property (CE && hold |=> s.core == CORE_HOLD && !CFG_VALID ##0
        !WB_ACK) else $error("hold not honoured");
    bus_answer_a: assert property (bus_request |-> bus_reply)
        else $error("bus answer out of time");
    latch_hold_a: assert property (CE && s.core == CORE_RUN && !hold |=>
        $stable(s.peak_l) && $stable(s.serial)) else $error("latched straps moved");

endmodule // eq_setting_pin_decoder

/* File: eq_setting_pin_decoder_tb.sv */
`timescale 1ns/1ps
module eq_setting_pin_decoder_tb;
    // ==========================================================
    // Signals
    // ==========================================================
    logic clk, rst_b, ce, serial, mode_sel, ack, err, smode, valid, e;
    eq_cfg_pkg::lvl_e lv_en, lv_prof, lv_sw, lv_gain, lv_peak;
    eq_cfg_pkg::lvl_e lv_tab [3] = '{eq_cfg_pkg::LVL_LOW, eq_cfg_pkg::LVL_OPEN, eq_cfg_pkg::LVL_HIGH};
    eq_cfg_pkg::strap_s pu, pd;
    eq_cfg_pkg::wb_req_s req;
    eq_cfg_pkg::ch_cfg_s [7:0] cfg;
    logic [31:0] rdat, q;
    logic [7:0] pwrdn;
    int n_errors = 0;
    int check_count = 0;

    strap_board u_strap_board (.en_lvl(lv_en), .prof_lvl(lv_prof), .swing_lvl(lv_sw),
        .gain_lvl(lv_gain), .peak_lvl(lv_peak), .serial(serial), .pu(pu), .pd(pd),
        .mode_sel(mode_sel));
    eq_setting_pin_decoder u_eq_setting_pin_decoder (.CLK(clk), .RST_B(rst_b), .CE(ce),
        .MODE_SEL(mode_sel), .STRAP_PU(pu), .STRAP_PD(pd), .WB_REQ(req), .WB_ACK(ack),
        .WB_ERR(err), .WB_DAT(rdat), .CH_CFG(cfg), .CH_PWRDN(pwrdn), .SERIAL_MODE(smode),
        .CFG_VALID(valid));

    // ==========================================================
    // Shared tasks
    // ==========================================================
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    function automatic logic [7:0] exp_cfg(input logic s, input eq_cfg_pkg::lvl_e p,
        input eq_cfg_pkg::lvl_e g, input eq_cfg_pkg::lvl_e w);
        logic [3:0] pk;
        logic [1:0] gn;
        pk = (p == eq_cfg_pkg::LVL_HIGH) ? (s ? 4'h9 : 4'he) :
             (p == eq_cfg_pkg::LVL_OPEN) ? (s ? 4'h5 : 4'h9) : (s ? 4'h3 : 4'h5);
        gn = (g == eq_cfg_pkg::LVL_HIGH) ? (s ? 2'h2 : 2'h3) :
             (g == eq_cfg_pkg::LVL_OPEN) ? (s ? 2'h1 : 2'h2) : (s ? 2'h0 : 2'h1);
        return {pk, gn, (w == eq_cfg_pkg::LVL_HIGH) ? 2'h3 : (w == eq_cfg_pkg::LVL_OPEN) ? 2'h2 : 2'h1};
    endfunction

    task automatic wait_valid();
        for (int k = 0; k < 20; k++) begin
            @(posedge clk);
            #1;
            if (valid === 1'b1) break;
        end
        check(valid, 1'b1);
    endtask

    // Mode select only moves while reset is held
    task automatic do_reset(input logic ser);
        @(posedge clk);
        rst_b <= 1'b0;
        serial <= ser;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        wait_valid();
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] rq, output logic er);
        @(posedge clk);
        req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hf, dat: d};
        // The wait ends on ack or err; only the watchdog ends it if neither comes
        do begin
            @(posedge clk);
        end while (ack !== 1'b1 && err !== 1'b1);
        rq = rdat;
        er = err;
        req <= '0;
        @(posedge clk);
        #1;
    endtask

    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic pin_maps();
        for (int p = 0; p < 3; p++) begin
            for (int l = 0; l < 3; l++) begin
                @(posedge clk);
                lv_prof <= lv_tab[p];
                lv_peak <= lv_tab[l];
                lv_gain <= lv_tab[l];
                lv_sw <= lv_tab[l];
                lv_en <= eq_cfg_pkg::LVL_OPEN;
                do_reset(1'b0);
                check(smode, 1'b0);
                check(pwrdn, 8'h00);
                for (int c = 0; c < 8; c++) begin
                    check(cfg[c], exp_cfg(p == 2, lv_tab[l], lv_tab[l], lv_tab[l]));
                end
            end
        end
    endtask

    // Mixed levels catch swapped fields; power follows the strap live
    task automatic pin_enable();
        @(posedge clk);
        lv_prof <= eq_cfg_pkg::LVL_LOW;
        lv_peak <= eq_cfg_pkg::LVL_HIGH;
        lv_gain <= eq_cfg_pkg::LVL_LOW;
        lv_sw <= eq_cfg_pkg::LVL_OPEN;
        lv_en <= eq_cfg_pkg::LVL_HIGH;
        do_reset(1'b0);
        check(pwrdn, 8'hff);
        check(cfg[5], 8'he6);
        wb(1'b1, eq_cfg_pkg::CHAN_OFF, 32'h33, q, e);
        check(e, 1'b0);
        check(cfg[0], 8'he6);
        lv_en <= eq_cfg_pkg::LVL_OPEN;
        repeat (3) @(posedge clk);
        #1;
        check(pwrdn, 8'h00);
    endtask

    task automatic serial_chan();
        @(posedge clk);
        lv_en <= eq_cfg_pkg::LVL_OPEN;
        do_reset(1'b1);
        check(smode, 1'b1);
        check(pwrdn, 8'h00);
        check(cfg, {8{8'h9a}});
        for (int c = 0; c < 16; c++) begin
            wb(1'b1, eq_cfg_pkg::CHAN_OFF + 8'h04, {24'h0, 4'(c), 2'(c), ~2'(c)}, q, e);
            wb(1'b0, eq_cfg_pkg::CHAN_OFF + 8'h04, 32'h0, q, e);
            check(q[7:0], {4'(c), 2'(c), ~2'(c)});
            check(cfg[1], {4'(c), 2'(c), ~2'(c)});
            check({cfg[2], cfg[0]}, 16'h9a9a);
        end
        wb(1'b1, eq_cfg_pkg::CHAN_OFF, 32'h5c, q, e);
        check(cfg[0], 8'h5c);
        check(cfg[1], {4'hf, 2'h3, 2'h0});
        wb(1'b0, eq_cfg_pkg::STATUS_OFF, 32'h0, q, e);
        check(q, 32'h295);
        wb(1'b1, eq_cfg_pkg::POWER_OFF, 32'h05, q, e);
        check(pwrdn, 8'h05);
        wb(1'b0, 8'h80, 32'h0, q, e);
        check({e, q}, 33'h0);
    endtask

    task automatic serial_enable();
        @(posedge clk);
        lv_en <= eq_cfg_pkg::LVL_HIGH;
        do_reset(1'b1);
        check(pwrdn, 8'hff);
        wb(1'b1, eq_cfg_pkg::CHAN_OFF + 8'h0c, 32'h11, q, e);
        check(cfg[3], 8'h11);
        lv_en <= eq_cfg_pkg::LVL_LOW;
        repeat (3) @(posedge clk);
        wb(1'b0, eq_cfg_pkg::CHAN_OFF + 8'h0c, 32'h0, q, e);
        check(e, 1'b1);
        check({valid, cfg[3]}, 9'h09a);
        @(posedge clk);
        lv_en <= eq_cfg_pkg::LVL_OPEN;
        wait_valid();
        check(pwrdn, 8'h00);
        check(cfg[3], 8'h9a);
    endtask

    // ==========================================================
    // Clock, watchdog and main sequence
    // ==========================================================
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // The whole run needs well under ten thousand cycles
    initial begin
        #80000;
        n_errors++;
        complete_run();
    end

    initial begin
        rst_b = 1'b0;
        ce = 1'b1;
        serial = 1'b0;
        req = '0;
        lv_en = eq_cfg_pkg::LVL_OPEN;
        lv_prof = eq_cfg_pkg::LVL_OPEN;
        lv_sw = eq_cfg_pkg::LVL_OPEN;
        lv_gain = eq_cfg_pkg::LVL_OPEN;
        lv_peak = eq_cfg_pkg::LVL_OPEN;
        pin_maps();
        pin_enable();
        serial_chan();
        serial_enable();
        complete_run();
    end
endmodule // eq_setting_pin_decoder_tb

/* File: strap_board.sv */
`timescale 1ns/1ps
// ==========================================================
// Board straps: three-state pins seen through weak pulls
// ==========================================================
module strap_board (
    input wire eq_cfg_pkg::lvl_e en_lvl,
    input wire eq_cfg_pkg::lvl_e prof_lvl,
    input wire eq_cfg_pkg::lvl_e swing_lvl,
    input wire eq_cfg_pkg::lvl_e gain_lvl,
    input wire eq_cfg_pkg::lvl_e peak_lvl,
    input wire logic serial,
    output eq_cfg_pkg::strap_s pu,
    output eq_cfg_pkg::strap_s pd,
    output logic mode_sel
);
    // An open pin follows whichever weak pull is applied
    function automatic logic [1:0] sense(input eq_cfg_pkg::lvl_e l);
        return (l == eq_cfg_pkg::LVL_HIGH) ? 2'h3 : (l == eq_cfg_pkg::LVL_OPEN) ? 2'h2 : 2'h0;
    endfunction
    assign {pu.enable, pd.enable} = sense(en_lvl);
    assign {pu.profile, pd.profile} = sense(prof_lvl);
    assign {pu.swing, pd.swing} = sense(swing_lvl);
    assign {pu.gain, pd.gain} = sense(gain_lvl);
    assign {pu.peak, pd.peak} = sense(peak_lvl);
    // Bench changes serial only while reset is held
    assign mode_sel = serial;
endmodule // strap_board
